// ===== src/ddr2_mode_pkg.sv
/*
 * constants for the ddr2 command decoder and mode register block:
 * command codes, bank selects, field positions, reset values, counts.
 * assumes a 50 MHz core clock that oversamples the memory clock pin.
 */
package ddr2_mode_pkg;
	localparam int CORE_HZ = 50000000;
	localparam int ADDR_W = 13;
	localparam int BANK_W = 3;
	// command code {ras_n, cas_n, we_n}
	localparam logic [2:0] CMD_MODE_SET = 3'h0;
	localparam logic [2:0] CMD_REFRESH = 3'h1;
	localparam logic [2:0] CMD_PRECHARGE = 3'h2;
	localparam logic [2:0] CMD_NOP = 3'h7;
	// bank selects of the four registers
	localparam logic [2:0] BANK_MR = 3'h0;
	localparam logic [2:0] BANK_EMR1 = 3'h1;
	localparam logic [2:0] BANK_EMR2 = 3'h2;
	localparam logic [2:0] BANK_EMR3 = 3'h3;
	// mode register field positions
	localparam int MR_BL_LO = 0;
	localparam int MR_BT = 3;
	localparam int MR_CL_LO = 4;
	localparam int MR_TM = 7;
	localparam int MR_DLL_RST = 8;
	localparam int MR_WR_LO = 9;
	// extended mode register 1 field positions
	localparam int EMR_DLL_DIS = 0;
	localparam int EMR_DS = 1;
	localparam int EMR_RTT0 = 2;
	localparam int EMR_AL_LO = 3;
	localparam int EMR_RTT1 = 6;
	localparam int EMR_OCD_LO = 7;
	localparam int EMR_DQSN_DIS = 10;
	localparam int EMR_RDQS = 11;
	// reset values (register contents are undefined at power-up; zeros chosen)
	localparam logic [12:0] MR_RESET = 13'h0000;
	localparam logic [12:0] EMR_RESET = 13'h0000;
	localparam logic [2:0] OCD_DEFAULT = 3'h7;
	localparam logic [2:0] OCD_EXIT = 3'h0;
	// dll lock wait in memory clocks after enable plus reset
	localparam int DLL_LOCK_CLOCKS = 200;
	localparam logic [7:0] DLL_LOCK_CNT = 8'(DLL_LOCK_CLOCKS);
endpackage : ddr2_mode_pkg

// ===== src/ddr2_mode_store.sv
/*
 * holds the four mode register words, one written per mode-set command.
 * assumes writes and reads on the core clock; read data is registered.
 */
`timescale 1ns/100ps
module ddr2_mode_store #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 4
) (
	input wire logic clk_in, // core clock
	input wire logic rst_in, // synchronous reset, high
	input wire logic wr_en_in, // write strobe
	input wire logic [$clog2(DEPTH)-1:0] wr_sel_in, // written entry
	input wire logic [WIDTH-1:0] wr_data_in, // write word
	input wire logic [$clog2(DEPTH)-1:0] rd_sel_in, // read entry
	output logic [WIDTH-1:0] rd_data_out // registered read word
);
	logic [WIDTH-1:0] mem_reg [DEPTH];

	// write port
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			for (int i = 0; i < DEPTH; i++)
				mem_reg[i] <= '0;
		else if (wr_en_in)
			mem_reg[wr_sel_in] <= wr_data_in;
	end

	// registered read port
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			rd_data_out <= '0;
		else
			rd_data_out <= mem_reg[rd_sel_in];
	end
endmodule : ddr2_mode_store

// ===== src/ddr2_mode_ctrl.sv
/*
 * device-side command decoder for ddr2 mode and extended mode registers.
 * samples the memory clock and command pins on the core clock, decodes
 * commands on memory clock rising edges and drives decoded settings.
 * assumes the core clock is well above twice the memory clock rate.
 */
// Functional notes
// R1: controller runs clock 200 us first
// R2: controller gives NOP then raises CKE
// R3: NOP for 400 ns, then precharge all
// R4: then write extended register two
// R5: then write extended register three
// R6: then enable DLL in extended register one
// R7: then mode set with DLL reset
// R8: then precharge all, two or more refreshes
// R9: then mode set without DLL reset
// R10: calibrate no sooner than 200 clocks later
// R11: skipped calibration: default then exit writes
// R12: every mode set gives all fields
// R13: mode writes never touch array contents
// R14: mode set latches address on all-low command
// R15: mode set only when precharged, CKE high
// R16: burst length, burst type, CAS latency fields
// R17: test mode, DLL reset, write recovery fields
// R18: controller computes write recovery rounded up
// R19: extended register one field layout
// R20: self refresh turns DLL off, exit resets it
// R21: wait 200 clocks after DLL reset to read
// R22: redundant strobe bit defaults disabled
// R23: chip select high masks every command
// R24: complementary strobe only when enabled
// R25: controller keeps steps in order
`timescale 1ns/100ps
module ddr2_mode_ctrl (
	input wire logic CORE_CLK_IN, // 50 MHz core clock
	input wire logic RST_IN, // synchronous reset, high
	input wire logic MEM_CLK_IN, // memory clock pin
	input wire logic CKE_IN, // clock enable pin
	input wire logic CS_N_IN, // chip select, low
	input wire logic RAS_N_IN, // row strobe, low
	input wire logic CAS_N_IN, // column strobe, low
	input wire logic WE_N_IN, // write enable, low
	input wire logic [2:0] BA_IN, // bank address
	input wire logic [12:0] ADDR_IN, // address bus
	output logic [2:0] BURST_LEN_OUT, // burst length code
	output logic BURST_INTERLEAVE_OUT, // burst type
	output logic [2:0] CAS_LAT_OUT, // CAS latency code
	output logic CAS_LAT_BAD_OUT, // unsupported CAS or burst code
	output logic TEST_MODE_OUT, // test mode bit
	output logic [2:0] WRITE_REC_OUT, // write recovery code
	output logic DLL_ON_OUT, // DLL enabled
	output logic DLL_LOCKED_OUT, // DLL lock wait elapsed
	output logic REDUCED_DRIVE_OUT, // reduced drive strength
	output logic [1:0] ODT_SEL_OUT, // termination {A6,A2}
	output logic [2:0] ADD_LAT_OUT, // additive latency
	output logic [2:0] OCD_MODE_OUT, // calibration control
	output logic DQS_N_EN_OUT, // complementary strobe used
	output logic RDQS_EN_OUT, // redundant read strobe
	output logic SELF_REFRESH_OUT, // in self refresh
	output logic [3:0] PROGRAMMED_OUT, // registers written, bit per bank
	output logic [12:0] EMR2_OUT, // extended register two word
	output logic [12:0] EMR3_OUT // extended register three word
);
	logic [2:0] clk_sync_reg; // [0] first stage, [1] second, [2] history
	logic [1:0] cke_sync_reg;
	logic [1:0] cs_sync_reg, ras_sync_reg, cas_sync_reg, we_sync_reg;
	logic [2:0] ba_s1_reg, ba_s2_reg;
	logic [12:0] addr_s1_reg, addr_s2_reg;
	logic mem_rise;
	logic cmd_valid;
	logic [2:0] cmd_code;
	logic mode_set;
	logic refresh;
	logic cke_prev_reg;
	logic [12:0] mr_reg, emr1_reg;
	logic [7:0] lock_cnt_reg;
	logic [1:0] rd_sel_reg;
	logic [12:0] store_rd;

	// true when a cas latency code is one the device supports (2..6)
	function automatic logic cas_ok(input logic [2:0] code);
		cas_ok = (code >= 3'h2) && (code <= 3'h6);
	endfunction : cas_ok

	// true when burst length code selects 4 or 8
	function automatic logic burst_ok(input logic [2:0] code);
		burst_ok = (code == 3'h2) || (code == 3'h3);
	endfunction : burst_ok

	// two-stage synchronisers on every pin
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RST_IN)
		begin
			clk_sync_reg <= 3'h0;
			cke_sync_reg <= 2'h0;
			cs_sync_reg <= 2'h3;
			ras_sync_reg <= 2'h3;
			cas_sync_reg <= 2'h3;
			we_sync_reg <= 2'h3;
			ba_s1_reg <= 3'h0;
			ba_s2_reg <= 3'h0;
			addr_s1_reg <= 13'h0000;
			addr_s2_reg <= 13'h0000;
		end
		else
		begin
			clk_sync_reg <= {clk_sync_reg[1:0], MEM_CLK_IN};
			cke_sync_reg <= {cke_sync_reg[0], CKE_IN};
			cs_sync_reg <= {cs_sync_reg[0], CS_N_IN};
			ras_sync_reg <= {ras_sync_reg[0], RAS_N_IN};
			cas_sync_reg <= {cas_sync_reg[0], CAS_N_IN};
			we_sync_reg <= {we_sync_reg[0], WE_N_IN};
			ba_s1_reg <= BA_IN;
			ba_s2_reg <= ba_s1_reg;
			addr_s1_reg <= ADDR_IN;
			addr_s2_reg <= addr_s1_reg;
		end
	end

	// edge of the memory clock seen after the second stage
	assign mem_rise = clk_sync_reg[1] & ~clk_sync_reg[2];

	// command decode; chip select high masks everything
	assign cmd_valid = mem_rise & ~cs_sync_reg[1]; // R23
	assign cmd_code = {ras_sync_reg[1], cas_sync_reg[1], we_sync_reg[1]};
	assign mode_set = cmd_valid && cmd_code == ddr2_mode_pkg::CMD_MODE_SET
		&& cke_sync_reg[1]; // R14
	assign refresh = cmd_valid && cmd_code == ddr2_mode_pkg::CMD_REFRESH;

	// mode register write, whole word latched each time
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RST_IN)
			mr_reg <= ddr2_mode_pkg::MR_RESET;
		else if (mode_set && ba_s2_reg == ddr2_mode_pkg::BANK_MR)
			mr_reg <= addr_s2_reg; // R14 R12
	end

	// extended register one write
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RST_IN)
			emr1_reg <= ddr2_mode_pkg::EMR_RESET; // R22
		else if (mode_set && ba_s2_reg == ddr2_mode_pkg::BANK_EMR1)
			emr1_reg <= addr_s2_reg; // R19
	end

	// programmed flags, one per register; no array state exists here
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RST_IN)
			PROGRAMMED_OUT <= 4'h0;
		else if (mode_set && ba_s2_reg[2] == 1'b0)
			PROGRAMMED_OUT[ba_s2_reg[1:0]] <= 1'b1; // R13
	end

	// self refresh: refresh with CKE low enters, CKE high exits
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RST_IN)
		begin
			SELF_REFRESH_OUT <= 1'b0;
			cke_prev_reg <= 1'b0;
		end
		else if (mem_rise)
		begin
			cke_prev_reg <= cke_sync_reg[1];
			if (refresh && cke_prev_reg && !cke_sync_reg[1])
				SELF_REFRESH_OUT <= 1'b1; // R20
			else if (SELF_REFRESH_OUT && cke_sync_reg[1])
				SELF_REFRESH_OUT <= 1'b0; // R20
		end
	end

	// dll lock counter restarts on dll reset or self refresh exit
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RST_IN)
			lock_cnt_reg <= ddr2_mode_pkg::DLL_LOCK_CNT;
		else if ((mode_set && ba_s2_reg == ddr2_mode_pkg::BANK_MR && addr_s2_reg[ddr2_mode_pkg::MR_DLL_RST])
			|| SELF_REFRESH_OUT || !DLL_ON_OUT)
			lock_cnt_reg <= ddr2_mode_pkg::DLL_LOCK_CNT; // R20 R21
		else if (mem_rise && lock_cnt_reg != 8'h00)
			lock_cnt_reg <= lock_cnt_reg - 8'h01;
	end

	// decoded mode fields, registered
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RST_IN)
		begin
			BURST_LEN_OUT <= 3'h0;
			BURST_INTERLEAVE_OUT <= 1'b0;
			CAS_LAT_OUT <= 3'h0;
			CAS_LAT_BAD_OUT <= 1'b0;
			TEST_MODE_OUT <= 1'b0;
			WRITE_REC_OUT <= 3'h0;
		end
		else
		begin
			BURST_LEN_OUT <= mr_reg[ddr2_mode_pkg::MR_BL_LO +: 3]; // R16
			BURST_INTERLEAVE_OUT <= mr_reg[ddr2_mode_pkg::MR_BT]; // R16
			CAS_LAT_OUT <= mr_reg[ddr2_mode_pkg::MR_CL_LO +: 3]; // R16
			CAS_LAT_BAD_OUT <= PROGRAMMED_OUT[0] && !(cas_ok(mr_reg[ddr2_mode_pkg::MR_CL_LO +: 3])
				&& burst_ok(mr_reg[ddr2_mode_pkg::MR_BL_LO +: 3])); // R16
			TEST_MODE_OUT <= mr_reg[ddr2_mode_pkg::MR_TM]; // R17
			WRITE_REC_OUT <= mr_reg[ddr2_mode_pkg::MR_WR_LO +: 3]; // R17
		end
	end

	// decoded extended fields, dll forced off in self refresh
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RST_IN)
		begin
			DLL_ON_OUT <= 1'b0;
			DLL_LOCKED_OUT <= 1'b0;
			REDUCED_DRIVE_OUT <= 1'b0;
			ODT_SEL_OUT <= 2'h0;
			ADD_LAT_OUT <= 3'h0;
			OCD_MODE_OUT <= 3'h0;
			DQS_N_EN_OUT <= 1'b0;
			RDQS_EN_OUT <= 1'b0;
		end
		else
		begin
			DLL_ON_OUT <= PROGRAMMED_OUT[1] && !emr1_reg[ddr2_mode_pkg::EMR_DLL_DIS]
				&& !SELF_REFRESH_OUT; // R19 R20
			DLL_LOCKED_OUT <= DLL_ON_OUT && lock_cnt_reg == 8'h00; // R21
			REDUCED_DRIVE_OUT <= emr1_reg[ddr2_mode_pkg::EMR_DS]; // R19
			ODT_SEL_OUT <= {emr1_reg[ddr2_mode_pkg::EMR_RTT1], emr1_reg[ddr2_mode_pkg::EMR_RTT0]}; // R19
			ADD_LAT_OUT <= emr1_reg[ddr2_mode_pkg::EMR_AL_LO +: 3]; // R19
			OCD_MODE_OUT <= emr1_reg[ddr2_mode_pkg::EMR_OCD_LO +: 3]; // R19
			DQS_N_EN_OUT <= PROGRAMMED_OUT[1] && !emr1_reg[ddr2_mode_pkg::EMR_DQSN_DIS]; // R24
			RDQS_EN_OUT <= emr1_reg[ddr2_mode_pkg::EMR_RDQS]; // R22
		end
	end

	// cycle read select over the store for the two extended words
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RST_IN)
			rd_sel_reg <= ddr2_mode_pkg::BANK_EMR2[1:0];
		else if (rd_sel_reg == ddr2_mode_pkg::BANK_EMR2[1:0])
			rd_sel_reg <= ddr2_mode_pkg::BANK_EMR3[1:0];
		else
			rd_sel_reg <= ddr2_mode_pkg::BANK_EMR2[1:0];
	end

	// capture store read data; select leads data by one cycle
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RST_IN)
		begin
			EMR2_OUT <= 13'h0000;
			EMR3_OUT <= 13'h0000;
		end
		else if (rd_sel_reg == ddr2_mode_pkg::BANK_EMR3[1:0])
			EMR2_OUT <= store_rd;
		else
			EMR3_OUT <= store_rd;
	end

	ddr2_mode_store #(
		.WIDTH(13),
		.DEPTH(4)
	) u_store (
		.clk_in(CORE_CLK_IN),
		.rst_in(RST_IN),
		.wr_en_in(mode_set && ba_s2_reg[2] == 1'b0), // R14
		.wr_sel_in(ba_s2_reg[1:0]),
		.wr_data_in(addr_s2_reg),
		.rd_sel_in(rd_sel_reg),
		.rd_data_out(store_rd)
	);
endmodule : ddr2_mode_ctrl

// ===== tb/ddr2_mode_ctrl_sva.sv
/* checker for the ddr2 mode register decoder: field decode, masking, dll lock wait.
 assumes it is bound to the decoder top and sees only its ports. */
`timescale 1ns/100ps
module ddr2_mode_ctrl_chk (
	input wire logic CORE_CLK_IN, RST_IN, MEM_CLK_IN, CKE_IN, CS_N_IN, RAS_N_IN, CAS_N_IN, WE_N_IN,
	input wire logic [2:0] BA_IN,
	input wire logic [12:0] ADDR_IN,
	input wire logic [2:0] BURST_LEN_OUT, CAS_LAT_OUT, WRITE_REC_OUT, ADD_LAT_OUT, OCD_MODE_OUT,
	input wire logic BURST_INTERLEAVE_OUT, TEST_MODE_OUT, DLL_ON_OUT, DLL_LOCKED_OUT, REDUCED_DRIVE_OUT,
	input wire logic DQS_N_EN_OUT, RDQS_EN_OUT, SELF_REFRESH_OUT,
	input wire logic [1:0] ODT_SEL_OUT,
	input wire logic [3:0] PROGRAMMED_OUT,
	input wire logic [12:0] EMR2_OUT
);
	logic clk_q_reg;
	logic [12:0] cap_reg;
	logic [8:0] lock_cnt_reg;
	logic rise, set_cmd, mr_wr, emr1_wr;
	// memory clock edge and mode-set decode on the raw pins
	assign rise = MEM_CLK_IN & ~clk_q_reg;
	assign set_cmd = rise & ~CS_N_IN & ~RAS_N_IN & ~CAS_N_IN & ~WE_N_IN & CKE_IN & ~BA_IN[2];
	assign mr_wr = set_cmd & (BA_IN[1:0] == 2'h0);
	assign emr1_wr = set_cmd & (BA_IN[1:0] == 2'h1);
	// edge history and the last written word
	always_ff @(posedge CORE_CLK_IN)
	begin
		clk_q_reg <= MEM_CLK_IN;
		if (set_cmd)
			cap_reg <= ADDR_IN;
	end
	// memory clocks since the last dll reset, held at zero in self refresh
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RST_IN || (mr_wr && ADDR_IN[8]) || SELF_REFRESH_OUT)
			lock_cnt_reg <= 9'h000;
		else if (rise && lock_cnt_reg != 9'h1FF)
			lock_cnt_reg <= lock_cnt_reg + 9'h001;
	end
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (RST_IN);
	mr_burst_a: assert property (mr_wr |-> ##6 BURST_LEN_OUT == cap_reg[2:0] &&
		BURST_INTERLEAVE_OUT == cap_reg[3] && CAS_LAT_OUT == cap_reg[6:4]) else $error("burst fields wrong");
	mr_misc_a: assert property (mr_wr |-> ##6 TEST_MODE_OUT == cap_reg[7] &&
		WRITE_REC_OUT == cap_reg[11:9]) else $error("test or recovery field wrong");
	emr1_fields_a: assert property (emr1_wr |-> ##6 REDUCED_DRIVE_OUT == cap_reg[1] &&
		ADD_LAT_OUT == cap_reg[5:3] && OCD_MODE_OUT == cap_reg[9:7] && ODT_SEL_OUT == {cap_reg[6], cap_reg[2]})
		else $error("extended fields wrong");
	strobe_sel_a: assert property (emr1_wr |-> ##6 DQS_N_EN_OUT == !cap_reg[10]) else $error("strobe select wrong");
	rdqs_bit_a: assert property (emr1_wr |-> ##6 RDQS_EN_OUT == cap_reg[11]) else $error("rdqs bit wrong");
	emr2_word_a: assert property (set_cmd && BA_IN[1:0] == 2'h2 |-> ##6 EMR2_OUT == cap_reg)
		else $error("register two word wrong");
	mr_written_a: assert property (mr_wr |-> ##6 PROGRAMMED_OUT[0]) else $error("write not flagged");
	cs_mask_a: assert property (rise && CS_N_IN |=> $stable({BURST_LEN_OUT, CAS_LAT_OUT, OCD_MODE_OUT,
		PROGRAMMED_OUT})[*6]) else $error("deselected command took effect");
	sr_dll_off_a: assert property ($rose(SELF_REFRESH_OUT) |-> ##[0:2] !DLL_ON_OUT) else $error("dll on in refresh");
	lock_wait_a: assert property ($rose(DLL_LOCKED_OUT) |-> lock_cnt_reg >= 9'h0C7) else $error("lock too early");
	cover property (mr_wr);
	cover property ($rose(SELF_REFRESH_OUT));
	cover property ($rose(DLL_LOCKED_OUT));
endmodule : ddr2_mode_ctrl_chk
bind ddr2_mode_ctrl ddr2_mode_ctrl_chk u_chk (.CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN),
	.MEM_CLK_IN(MEM_CLK_IN), .CKE_IN(CKE_IN), .CS_N_IN(CS_N_IN), .RAS_N_IN(RAS_N_IN), .CAS_N_IN(CAS_N_IN),
	.WE_N_IN(WE_N_IN), .BA_IN(BA_IN), .ADDR_IN(ADDR_IN), .BURST_LEN_OUT(BURST_LEN_OUT),
	.CAS_LAT_OUT(CAS_LAT_OUT), .WRITE_REC_OUT(WRITE_REC_OUT), .ADD_LAT_OUT(ADD_LAT_OUT),
	.OCD_MODE_OUT(OCD_MODE_OUT), .BURST_INTERLEAVE_OUT(BURST_INTERLEAVE_OUT), .TEST_MODE_OUT(TEST_MODE_OUT),
	.DLL_ON_OUT(DLL_ON_OUT), .DLL_LOCKED_OUT(DLL_LOCKED_OUT), .REDUCED_DRIVE_OUT(REDUCED_DRIVE_OUT),
	.DQS_N_EN_OUT(DQS_N_EN_OUT), .RDQS_EN_OUT(RDQS_EN_OUT), .SELF_REFRESH_OUT(SELF_REFRESH_OUT),
	.ODT_SEL_OUT(ODT_SEL_OUT), .PROGRAMMED_OUT(PROGRAMMED_OUT), .EMR2_OUT(EMR2_OUT));

// ===== tb/ddr2_ctrl_model.sv
/* memory controller model: free-running memory clock and at most one command per two memory clocks.
 assumes a 20 ns core clock, giving a 160 ns memory clock. */
`timescale 1ns/100ps
module ddr2_ctrl_model (
	input wire logic clk_in, // core clock
	output logic mem_clk_out, // memory clock
	output logic cke_out, // clock enable
	output logic cs_n_out, // chip select, low
	output logic [2:0] cmd_out, // {ras_n, cas_n, we_n}
	output logic [2:0] ba_out, // bank address
	output logic [12:0] addr_out // address
);
	logic [2:0] ph_reg = 3'h0;
	// clock runs from power-up, high in phases 0 to 3
	always_ff @(posedge clk_in)
		ph_reg <= ph_reg + 3'h1;
	assign mem_clk_out = ~ph_reg[2];
	// deselected with clock enable low until the sequence starts
	initial
	begin
		cke_out = 1'b0;
		cs_n_out = 1'b1;
		cmd_out = 3'h7;
		ba_out = 3'h0;
		addr_out = 13'h0000;
	end
	// one command around a rising edge, then NOP for a clock so commands stay spaced
	task automatic issue(input logic cs_n, input logic [2:0] cmd, input logic [2:0] ba,
		input logic [12:0] addr, input logic cke);
		@(posedge clk_in iff ph_reg == 3'h3);
		cs_n_out <= cs_n;
		cmd_out <= cmd;
		ba_out <= ba;
		addr_out <= addr;
		cke_out <= cke;
		@(posedge clk_in iff ph_reg == 3'h3);
		cs_n_out <= 1'b0;
		cmd_out <= 3'h7;
		ba_out <= ~ba; // released lines no longer show the word
		addr_out <= ~addr;
	endtask : issue
	// wait a number of memory clock rising edges
	task automatic wait_mclk(input int n);
		repeat (n) @(posedge clk_in iff ph_reg == 3'h7);
	endtask : wait_mclk
endmodule : ddr2_ctrl_model

// ===== tb/ddr2_mode_ctrl_test.sv
/* testbench for the ddr2 mode register decoder: runs the power-up sequence and
 checks decoded settings. assumes the controller model and bound checker. */
`timescale 1ns/100ps
module ddr2_mode_ctrl_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic mclk, cke, cs_n, bt, bad, tm, dll_on, locked, rdrv, dqsn, rdqs, sr;
	logic [2:0] cmd, ba, bl, cl, wr, al, ocd;
	logic [12:0] addr, emr2, emr3;
	logic [1:0] odt;
	logic [3:0] prog;
	int n_fail = 0;
	int compares = 0;
	ddr2_ctrl_model ctl (.clk_in(clk), .mem_clk_out(mclk), .cke_out(cke), .cs_n_out(cs_n), .cmd_out(cmd),
		.ba_out(ba), .addr_out(addr));
	ddr2_mode_ctrl dut (.CORE_CLK_IN(clk), .RST_IN(rst), .MEM_CLK_IN(mclk), .CKE_IN(cke), .CS_N_IN(cs_n),
		.RAS_N_IN(cmd[2]), .CAS_N_IN(cmd[1]), .WE_N_IN(cmd[0]), .BA_IN(ba), .ADDR_IN(addr),
		.BURST_LEN_OUT(bl), .BURST_INTERLEAVE_OUT(bt), .CAS_LAT_OUT(cl), .CAS_LAT_BAD_OUT(bad),
		.TEST_MODE_OUT(tm), .WRITE_REC_OUT(wr), .DLL_ON_OUT(dll_on), .DLL_LOCKED_OUT(locked),
		.REDUCED_DRIVE_OUT(rdrv), .ODT_SEL_OUT(odt), .ADD_LAT_OUT(al), .OCD_MODE_OUT(ocd),
		.DQS_N_EN_OUT(dqsn), .RDQS_EN_OUT(rdqs), .SELF_REFRESH_OUT(sr), .PROGRAMMED_OUT(prog),
		.EMR2_OUT(emr2), .EMR3_OUT(emr3));
	// core clock, 20 ns
	initial
		forever #10 clk = ~clk;
	// compare one value, counting mismatches
	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// one command, then let the decoded outputs settle
	task automatic go(input logic cs_n_v, input logic [2:0] c, input logic [2:0] b, input logic [12:0] a,
		input logic k);
		ctl.issue(cs_n_v, c, b, a, k);
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask : go
	task automatic close_out;
		$display("fails %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	// power-up sequence, field decode, masking, self refresh
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk(13'({prog, dll_on, locked}), 13'h0);
		ctl.wait_mclk(1250);
		go(1'b0, 3'h7, 3'h0, 13'h0000, 1'b1);
		ctl.wait_mclk(3);
		go(1'b0, 3'h2, 3'h0, 13'h0400, 1'b1);
		go(1'b0, 3'h0, 3'h2, 13'h0080, 1'b1);
		chk(emr2, 13'h0080);
		go(1'b0, 3'h0, 3'h3, 13'h0000, 1'b1);
		chk(emr3, 13'h0000);
		chk(13'(prog[3:2]), 13'h3);
		go(1'b0, 3'h0, 3'h1, 13'h0C16, 1'b1);
		chk(13'({dll_on, rdrv, odt, al, ocd, dqsn, rdqs}), 13'hD41);
		go(1'b0, 3'h0, 3'h0, 13'h095B, 1'b1);
		chk(13'({wr, tm, cl, bt, bl, bad}), 13'h8B6);
		go(1'b0, 3'h2, 3'h0, 13'h0400, 1'b1);
		go(1'b0, 3'h1, 3'h0, 13'h0000, 1'b1);
		go(1'b0, 3'h1, 3'h0, 13'h0000, 1'b1);
		go(1'b0, 3'h0, 3'h0, 13'h085B, 1'b1);
		chk(13'({wr, tm, cl, bt, bl, bad, sr}), 13'h116C);
		ctl.wait_mclk(192);
		chk(13'(locked), 13'h0);
		ctl.wait_mclk(4);
		chk(13'(locked), 13'h1);
		go(1'b0, 3'h0, 3'h1, 13'h0F96, 1'b1);
		chk(13'({ocd, al, rdqs}), 13'h75);
		go(1'b0, 3'h0, 3'h1, 13'h0C16, 1'b1);
		chk(13'({ocd, al, rdqs}), 13'h5);
		go(1'b1, 3'h0, 3'h0, 13'h0002, 1'b1);
		chk(13'({bl, prog}), 13'h3F);
		go(1'b0, 3'h0, 3'h0, 13'h0092, 1'b1);
		chk(13'({tm, cl, bad, bl}), 13'h9A);
		go(1'b0, 3'h1, 3'h0, 13'h0000, 1'b0);
		chk(13'({sr, dll_on}), 13'h2);
		go(1'b0, 3'h7, 3'h0, 13'h0000, 1'b1);
		chk(13'({sr, dll_on, locked}), 13'h2);
		go(1'b0, 3'h0, 3'h1, 13'h0016, 1'b1);
		chk(13'({dqsn, rdqs, rdrv}), 13'h5);
		close_out();
	end
	// cuts a hung run short
	initial
	begin
		repeat (40000) @(posedge clk);
		n_fail++;
		$display("[ERR] %0t run did not finish", $time);
		close_out();
	end
endmodule : ddr2_mode_ctrl_test
